//--- hw/txb_pkg.sv
// txb_pkg: constants and carrier types of the transmit buffer path.
// assumes: single CORE_CLK domain, Wishbone classic register access.
package txb_pkg;

  // ----------------------------------------------------------------
  // register map (byte offsets)
  // ----------------------------------------------------------------
  localparam logic [7:0] TXB_ADR_DATA = 8'h00;
  localparam logic [7:0] TXB_ADR_STAT = 8'h04;
  localparam logic [7:0] TXB_ADR_CFG = 8'h08;
  localparam logic [7:0] TXB_ADR_INFO = 8'h0C;

  localparam int TXB_CFG_DISCARD = 0;
  localparam int TXB_CFG_DEFCHK = 1;
  localparam int TXB_INFO_ERR = 31;
  localparam logic [1:0] TXB_CFG_RST = 2'h0;

  // ----------------------------------------------------------------
  // command word fields
  // ----------------------------------------------------------------
  localparam int TXB_CA_FIRST = 13;
  localparam int TXB_CA_LAST = 12;
  localparam int TXB_CA_OFF_LO = 16;
  localparam int TXB_CA_ALG_LO = 24;
  localparam int TXB_LEN_W = 11;

  // ----------------------------------------------------------------
  // status word fields
  // ----------------------------------------------------------------
  localparam int TXB_ST_ES = 15;
  localparam int TXB_ST_LOSS = 11;
  localparam int TXB_ST_NOCAR = 10;
  localparam int TXB_ST_LATE = 9;
  localparam int TXB_ST_EXCOL = 8;
  localparam int TXB_ST_EXDEF = 2;
  localparam int TXB_ST_DEFER = 0;

  // ----------------------------------------------------------------
  // sizes and counts
  // ----------------------------------------------------------------
  localparam int TXB_DF_AW = 9;
  localparam int TXB_DF_DEPTH = 512;
  localparam int TXB_SF_AW = 4;
  localparam int TXB_SF_DEPTH = 16;
  localparam logic [4:0] TXB_MAX_COLL = 5'h10;
  localparam int TXB_DEFER_BIT_TIMES = 24288;

  typedef enum logic [1:0] {
    TXB_K_DATA = 2'h0,
    TXB_K_CMDA = 2'h1,
    TXB_K_CMDB = 2'h2
  } txb_kind_t;

  typedef struct packed {
    txb_kind_t kind;
    logic eop;
    logic [3:0] be;
    logic [31:0] word;
  } txb_entry_t;

  typedef struct packed {
    logic loss_carrier;
    logic no_carrier;
    logic late_collision;
  } txb_line_t;

endpackage

//--- hw/txb_tx_path.sv
// txb_tx_path: host transmit path with data FIFO, line feed and status FIFO.
// assumes: Wishbone classic master, line side MAC that consumes words and
// reports collisions, deferral and the end of each transmission.
//
// Notes on behaviour
// - buffers of any byte alignment and edge length
// - packet starts only once fully stored
// - command words never reach the line side
// - command A always stored, B only first
// - whole offset and padding words dropped
// - one status word per packet queued
// - full status FIFO stalls next packet
// - discard mode keeps transmitter running when full
// - discard mode overrun shows zero used, blocks further status
// - discard mode overrun raises no error
// - packet tag copied into status 31:16
// - bit 15 ORs bits 11,10,9,8,2,1
// - bits 11 and 10 report carrier faults
// - bit 9 reports late collision
// - sixteen collisions abort and set bit 8
// - bits 6:3 carry the collision count
// - excessive deferral aborts and sets bit 2
// - bit 0 marks a deferred transmission
// - byte count mismatch raises error flag
// - differing command B words raise error flag
// - non-discard overrun raises error, drops status, stalls next packet
`timescale 1ns/1ns
module txb_tx_path
  import txb_pkg::*;
#(
  parameter int DEFER_LIMIT = TXB_DEFER_BIT_TIMES
) (
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  output logic [31:0] TX_WORD,
  output logic [3:0] TX_BE,
  output logic TX_LAST,
  output logic TX_VALID,
  input wire logic TX_READY,
  output logic TX_ABORT,
  input wire logic LINE_COLLISION,
  input wire logic LINE_DEFER,
  input wire logic LINE_BIT_TICK,
  input wire txb_line_t LINE_RESULT,
  input wire logic LINE_DONE,
  output logic TX_ERROR
);

  function automatic logic [2:0] txb_ones(input logic [3:0] v);
    txb_ones = {2'h0, v[0]} + {2'h0, v[1]} + {2'h0, v[2]} + {2'h0, v[3]};
  endfunction

  // ----------------------------------------------------------------
  // wishbone slave
  // ----------------------------------------------------------------
  logic ack_r;
  logic [31:0] dat_r;
  logic [1:0] cfg_r;
  logic err_r;
  logic acc, wr_data, rd_stat;
  assign acc = WB_CYC_I && WB_STB_I && !ack_r;
  assign wr_data = acc && WB_WE_I && WB_ADR_I == TXB_ADR_DATA;
  assign rd_stat = acc && !WB_WE_I && WB_ADR_I == TXB_ADR_STAT;
  assign WB_ACK_O = ack_r;
  assign WB_DAT_O = dat_r;
  assign TX_ERROR = err_r;

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= acc;
    end
  end

  // ----------------------------------------------------------------
  // status FIFO storage
  // ----------------------------------------------------------------
  logic [31:0] sf_mem [TXB_SF_DEPTH];
  logic [TXB_SF_AW-1:0] sf_wp_r, sf_rp_r;
  logic [TXB_SF_AW:0] sf_cnt_r;
  logic sf_ovr_r;
  logic sf_full, stat_push, sf_pop, sf_wr;
  logic [31:0] stat_word;
  assign sf_full = sf_cnt_r == TXB_SF_AW'(0) + (TXB_SF_AW+1)'(TXB_SF_DEPTH);
  assign sf_pop = rd_stat && sf_cnt_r != '0;
  assign sf_wr = stat_push && !sf_full && !sf_ovr_r;

  // ----------------------------------------------------------------
  // data FIFO storage
  // ----------------------------------------------------------------
  txb_entry_t df_mem [TXB_DF_DEPTH];
  logic [TXB_DF_AW-1:0] df_wp_r, df_rp_r;
  logic [TXB_DF_AW:0] df_cnt_r;
  logic [TXB_DF_AW:0] pkt_cnt_r;
  logic df_push, df_pop, df_full;
  txb_entry_t df_in, df_head;
  assign df_full = df_cnt_r == (TXB_DF_AW+1)'(TXB_DF_DEPTH);
  assign df_head = df_mem[df_rp_r];

  always_ff @(posedge CORE_CLK) begin
    if (acc) begin
      case (WB_ADR_I)
        TXB_ADR_STAT: dat_r <= (WB_WE_I || sf_cnt_r == '0) ? 32'h0000_0000 : sf_mem[sf_rp_r];
        TXB_ADR_CFG: dat_r <= {{30{1'b0}}, cfg_r};
        TXB_ADR_INFO: dat_r <= {err_r, 10'h000, sf_ovr_r ? 5'h00 : sf_cnt_r,
                                6'h00, 10'(TXB_DF_DEPTH) - df_cnt_r};
        default: dat_r <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      cfg_r <= TXB_CFG_RST;
    end else if (acc && WB_WE_I && WB_ADR_I == TXB_ADR_CFG && WB_SEL_I[0]) begin
      cfg_r <= WB_DAT_I[1:0];
    end
  end

  // ----------------------------------------------------------------
  // host intake: command words and buffer trimming
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    TXB_I_CMDA = 3'b001,
    TXB_I_CMDB = 3'b010,
    TXB_I_DATA = 3'b100
  } txb_in_st_t;
  txb_in_st_t in_st_r;
  logic [31:0] cmd_a_r, cmd_b_ref_r;
  logic [10:0] idx_r, tot_words;
  logic [11:0] span, mask, base;
  logic [4:0] off;
  logic cmdb_bad;
  logic [3:0] be;
  logic in_range;
  assign off = cmd_a_r[TXB_CA_OFF_LO +: 5];
  assign span = {7'h00, off} + {1'b0, cmd_a_r[TXB_LEN_W-1:0]};
  assign base = {idx_r[9:0], 2'b00};

  always_comb begin
    case (cmd_a_r[TXB_CA_ALG_LO +: 2])
      2'h1: mask = 12'h00F;
      2'h2: mask = 12'h01F;
      default: mask = 12'h003;
    endcase
    tot_words = 11'(((span + mask) & ~mask) >> 2);
    for (int k = 0; k < 4; k++) begin
      be[k] = (base + 12'(k)) >= {7'h00, off} && (base + 12'(k)) < span;
    end
    in_range = be != 4'h0;
  end

  always_comb begin
    df_in = '{kind: TXB_K_DATA, eop: 1'b0, be: be, word: WB_DAT_I};
    df_push = 1'b0;
    case (in_st_r)
      TXB_I_CMDA: begin
        df_in.kind = TXB_K_CMDA;
        df_push = wr_data;
      end
      TXB_I_CMDB: begin
        // command B only with first segment
        df_in.kind = TXB_K_CMDB;
        df_push = wr_data && cmd_a_r[TXB_CA_FIRST];
      end
      TXB_I_DATA: begin
        df_in.eop = cmd_a_r[TXB_CA_LAST] && (base + 12'h004) >= span;
        df_push = wr_data && in_range;
      end
      default: df_push = 1'b0;
    endcase
  end
  assign cmdb_bad = wr_data && in_st_r == TXB_I_CMDB && !cmd_a_r[TXB_CA_FIRST]
                    && WB_DAT_I != cmd_b_ref_r;

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      in_st_r <= TXB_I_CMDA;
      idx_r <= 11'h000;
    end else if (wr_data) begin
      case (in_st_r)
        TXB_I_CMDA: in_st_r <= TXB_I_CMDB;
        TXB_I_CMDB: begin
          idx_r <= 11'h000;
          in_st_r <= tot_words == 11'h000 ? TXB_I_CMDA : TXB_I_DATA;
        end
        TXB_I_DATA: begin
          idx_r <= idx_r + 11'h001;
          if (idx_r + 11'h001 == tot_words) begin
            in_st_r <= TXB_I_CMDA;
          end
        end
        default: in_st_r <= TXB_I_CMDA;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      cmd_a_r <= 32'h0000_0000;
      cmd_b_ref_r <= 32'h0000_0000;
    end else if (wr_data && in_st_r == TXB_I_CMDA) begin
      cmd_a_r <= WB_DAT_I;
    end else if (wr_data && in_st_r == TXB_I_CMDB && cmd_a_r[TXB_CA_FIRST]) begin
      cmd_b_ref_r <= WB_DAT_I;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (df_push && !df_full) begin
      df_mem[df_wp_r] <= df_in;
    end
  end

  // ----------------------------------------------------------------
  // line feed: store-and-forward drain
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    TXB_D_IDLE = 4'b0001,
    TXB_D_SEND = 4'b0010,
    TXB_D_FLUSH = 4'b0100,
    TXB_D_WAIT = 4'b1000
  } txb_dr_st_t;
  txb_dr_st_t dr_st_r;
  logic [15:0] tag_r;
  logic [10:0] len_r;
  logic [11:0] bytes_r;
  logic [4:0] coll_r;
  logic [15:0] defer_cnt_r;
  logic deferred_r;
  logic out_free, is_cmd, abort_now, active, start;
  assign out_free = !TX_VALID || TX_READY;
  assign is_cmd = df_head.kind != TXB_K_DATA;
  assign active = dr_st_r == TXB_D_SEND || dr_st_r == TXB_D_WAIT;
  assign abort_now = active && (coll_r == TXB_MAX_COLL
                     || (cfg_r[TXB_CFG_DEFCHK] && 32'(defer_cnt_r) > DEFER_LIMIT));
  // whole packet stored and status room, or discard mode set
  assign start = dr_st_r == TXB_D_IDLE && pkt_cnt_r != '0
                 && (!sf_full || cfg_r[TXB_CFG_DISCARD]);

  always_comb begin
    df_pop = 1'b0;
    case (dr_st_r)
      TXB_D_SEND: df_pop = !abort_now && (is_cmd || out_free);
      TXB_D_FLUSH: df_pop = 1'b1;
      default: df_pop = 1'b0;
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      dr_st_r <= TXB_D_IDLE;
    end else begin
      case (dr_st_r)
        TXB_D_IDLE: if (start) dr_st_r <= TXB_D_SEND;
        TXB_D_SEND: begin
          if (abort_now) begin
            dr_st_r <= TXB_D_FLUSH;
          end else if (df_pop && df_head.eop) begin
            dr_st_r <= TXB_D_WAIT;
          end
        end
        TXB_D_FLUSH: if (df_head.eop) dr_st_r <= TXB_D_IDLE;
        TXB_D_WAIT: if (LINE_DONE || abort_now) dr_st_r <= TXB_D_IDLE;
        default: dr_st_r <= TXB_D_IDLE;
      endcase
    end
  end

  // only data entries reach the line
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      TX_VALID <= 1'b0;
      TX_WORD <= 32'h0000_0000;
      TX_BE <= 4'h0;
      TX_LAST <= 1'b0;
    end else if (dr_st_r == TXB_D_SEND && df_pop && !is_cmd) begin
      TX_VALID <= 1'b1;
      TX_WORD <= df_head.word;
      TX_BE <= df_head.be;
      TX_LAST <= df_head.eop;
    end else if (TX_READY || abort_now) begin
      // a cut frame leaves no stale word on offer
      TX_VALID <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      TX_ABORT <= 1'b0;
    end else begin
      TX_ABORT <= abort_now && dr_st_r != TXB_D_FLUSH;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET || start) begin
      bytes_r <= 12'h000;
    end else if (df_pop && !is_cmd) begin
      bytes_r <= bytes_r + {9'h000, txb_ones(df_head.be)};
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      tag_r <= 16'h0000;
      len_r <= 11'h000;
    end else if (df_pop && df_head.kind == TXB_K_CMDB) begin
      tag_r <= df_head.word[31:16];
      len_r <= df_head.word[TXB_LEN_W-1:0];
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET || start) begin
      coll_r <= 5'h00;
    end else if (active && LINE_COLLISION && coll_r != TXB_MAX_COLL) begin
      coll_r <= coll_r + 5'h01;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET || start) begin
      defer_cnt_r <= 16'h0000;
      deferred_r <= 1'b0;
    end else if (active && LINE_DEFER) begin
      deferred_r <= 1'b1;
      if (LINE_BIT_TICK && defer_cnt_r != 16'hFFFF) begin
        defer_cnt_r <= defer_cnt_r + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // status word and status FIFO
  // ----------------------------------------------------------------
  logic st_late, st_excol, st_exdef;
  assign stat_push = (dr_st_r == TXB_D_WAIT && (LINE_DONE || abort_now))
                     || (dr_st_r == TXB_D_SEND && abort_now);
  assign st_late = LINE_RESULT.late_collision;
  assign st_excol = coll_r == TXB_MAX_COLL;
  assign st_exdef = abort_now && !st_excol;

  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[31:16] = tag_r;
    stat_word[TXB_ST_LOSS] = LINE_RESULT.loss_carrier;
    stat_word[TXB_ST_NOCAR] = LINE_RESULT.no_carrier;
    stat_word[TXB_ST_LATE] = st_late;
    stat_word[TXB_ST_EXCOL] = st_excol;
    stat_word[6:3] = coll_r[3:0];
    stat_word[TXB_ST_EXDEF] = st_exdef;
    stat_word[TXB_ST_DEFER] = deferred_r;
    stat_word[TXB_ST_ES] = |{stat_word[11:8], stat_word[2:1]};
  end

  always_ff @(posedge CORE_CLK) begin
    if (sf_wr) begin
      sf_mem[sf_wp_r] <= stat_word;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      sf_wp_r <= '0;
      sf_rp_r <= '0;
      sf_cnt_r <= '0;
    end else begin
      if (sf_wr) sf_wp_r <= sf_wp_r + TXB_SF_AW'(1);
      if (sf_pop) sf_rp_r <= sf_rp_r + TXB_SF_AW'(1);
      sf_cnt_r <= sf_cnt_r + (TXB_SF_AW+1)'(sf_wr) - (TXB_SF_AW+1)'(sf_pop);
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      sf_ovr_r <= 1'b0;
    end else if (stat_push && sf_full && cfg_r[TXB_CFG_DISCARD]) begin
      sf_ovr_r <= 1'b1;
    end else if (sf_pop) begin
      sf_ovr_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // data FIFO pointers
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      df_wp_r <= '0;
      df_rp_r <= '0;
      df_cnt_r <= '0;
      pkt_cnt_r <= '0;
    end else begin
      if (df_push && !df_full) df_wp_r <= df_wp_r + TXB_DF_AW'(1);
      if (df_pop) df_rp_r <= df_rp_r + TXB_DF_AW'(1);
      df_cnt_r <= df_cnt_r + (TXB_DF_AW+1)'(df_push && !df_full)
                  - (TXB_DF_AW+1)'(df_pop);
      pkt_cnt_r <= pkt_cnt_r + (TXB_DF_AW+1)'(df_push && !df_full && df_in.eop)
                   - (TXB_DF_AW+1)'(df_pop && df_head.eop);
    end
  end

  // ----------------------------------------------------------------
  // transmitter error flag
  // ----------------------------------------------------------------
  logic len_bad, ovr_err, err_set, err_clr;
  assign len_bad = stat_push && !abort_now && bytes_r != {1'b0, len_r};
  assign ovr_err = stat_push && sf_full && !cfg_r[TXB_CFG_DISCARD];
  assign err_set = len_bad || ovr_err || cmdb_bad || (df_push && df_full);
  assign err_clr = acc && WB_WE_I && WB_ADR_I == TXB_ADR_INFO && WB_SEL_I[3]
                   && WB_DAT_I[TXB_INFO_ERR];

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      err_r <= 1'b0;
    end else if (err_set) begin
      err_r <= 1'b1;
    end else if (err_clr) begin
      err_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_start_whole;
    @(posedge CORE_CLK) disable iff (RESET)
      (dr_st_r == TXB_D_IDLE && pkt_cnt_r == '0) |=> dr_st_r != TXB_D_SEND;
  endproperty
  a_start_whole: assert property (p_start_whole) else $error("send without whole packet");

  property p_stall_full;
    @(posedge CORE_CLK) disable iff (RESET)
      (dr_st_r == TXB_D_IDLE && sf_full && !cfg_r[TXB_CFG_DISCARD])
      |=> dr_st_r == TXB_D_IDLE;
  endproperty
  a_stall_full: assert property (p_stall_full) else $error("start with status full");

  property p_no_cmd_out;
    @(posedge CORE_CLK) disable iff (RESET)
      (df_pop && is_cmd) |=> !$rose(TX_VALID) || TX_WORD != $past(df_head.word);
  endproperty
  a_no_cmd_out: assert property (p_no_cmd_out) else $error("command word on line");

  property p_cmdb_skip;
    @(posedge CORE_CLK) disable iff (RESET)
      (wr_data && in_st_r == TXB_I_CMDB && !cmd_a_r[TXB_CA_FIRST]) |=>
      df_cnt_r <= $past(df_cnt_r);
  endproperty
  a_cmdb_skip: assert property (p_cmdb_skip) else $error("command B stored for later buffer");

  property p_tag;
    @(posedge CORE_CLK) disable iff (RESET)
      sf_wr |=> sf_mem[$past(sf_wp_r)][31:16] == $past(tag_r);
  endproperty
  a_tag: assert property (p_tag) else $error("status tag mismatch");

  property p_es;
    @(posedge CORE_CLK) disable iff (RESET)
      stat_push |-> stat_word[15] == (stat_word[11] | stat_word[10] | stat_word[9]
                    | stat_word[8] | stat_word[2] | stat_word[1]);
  endproperty
  a_es: assert property (p_es) else $error("error summary wrong");

  property p_resv;
    @(posedge CORE_CLK) disable iff (RESET)
      stat_push |-> stat_word[14:12] == 3'h0 && !stat_word[7] && !stat_word[1];
  endproperty
  a_resv: assert property (p_resv) else $error("reserved status bit set");

  property p_excol;
    @(posedge CORE_CLK) disable iff (RESET)
      (active && coll_r == TXB_MAX_COLL) |-> stat_push && stat_word[8] ##1 TX_ABORT;
  endproperty
  a_excol: assert property (p_excol) else $error("sixteen collisions not aborted");

  property p_ovr_hold;
    @(posedge CORE_CLK) disable iff (RESET)
      (sf_ovr_r && !sf_pop) |-> !sf_wr ##1 sf_ovr_r;
  endproperty
  a_ovr_hold: assert property (p_ovr_hold) else $error("status written during overrun");

  property p_discard_noerr;
    @(posedge CORE_CLK) disable iff (RESET)
      (stat_push && sf_full && cfg_r[TXB_CFG_DISCARD] && !len_bad && !cmdb_bad
       && !(df_push && df_full) && !err_r) |=> !err_r && sf_ovr_r;
  endproperty
  a_discard_noerr: assert property (p_discard_noerr) else $error("discard overrun flagged");

endmodule

//--- test/txb_line_model.sv
// txb_line_model: line side stand-in that takes words and ends packets.
// assumes: wired to the line ports of txb_tx_path on one clock.
`timescale 1ns/1ns
module txb_line_model
  import txb_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic valid,
  input wire logic last,
  input wire logic [3:0] be,
  input wire logic [31:0] word,
  input wire logic abort,
  input wire logic slow,
  input wire logic [4:0] ncoll,
  output logic ready,
  output logic coll,
  output logic done,
  output logic [11:0] nbytes,
  output logic [9:0] nwords,
  output logic [31:0] first,
  output logic [7:0] pkts
);
  logic st;
  logic sop;
  logic [4:0] cl;
  // ----------------------------------------------------------------
  // word intake, collisions, completion
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    coll <= 1'b0;
    done <= 1'b0;
    if (rst) begin
      ready <= 1'b0;
      st <= 1'b0;
      sop <= 1'b1;
      pkts <= 8'h00;
      nbytes <= 12'h000;
      nwords <= 10'h000;
      first <= 32'h0000_0000;
    end else if (abort) begin
      st <= 1'b0;
      sop <= 1'b1;
      ready <= 1'b0;
      pkts <= pkts + 8'h01;
    end else if (!st) begin
      ready <= slow ? ~ready : 1'b1;
      if (valid && ready) begin
        nbytes <= (sop ? 12'h000 : nbytes) + 12'($countones(be));
        nwords <= (sop ? 10'h000 : nwords) + 10'h001;
        if (sop) first <= word;
        sop <= last;
        if (last) begin
          st <= 1'b1;
          cl <= ncoll;
          ready <= 1'b0;
        end
      end
    end else if (cl != 5'h00) begin
      // one collision pulse every other cycle
      if (!coll) begin
        coll <= 1'b1;
        cl <= cl - 5'h01;
      end
    end else begin
      done <= 1'b1;
      st <= 1'b0;
      pkts <= pkts + 8'h01;
    end
  end
endmodule

//--- test/tx_buffer_fifo_status_path_bench.sv
// tx_buffer_fifo_status_path_bench: register level tests of txb_tx_path.
// assumes: txb_line_model on the line side, Wishbone classic host.
`timescale 1ns/1ns
module tx_buffer_fifo_status_path_bench;
  import txb_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, defer = 1'b0, slow = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat, q;
  logic ack, tv, tl, tr, ab, co, dn, terr;
  logic [31:0] tw, fw;
  logic [3:0] be;
  logic [4:0] ncoll = 5'h00;
  txb_line_t res = '0;
  logic [11:0] nbytes;
  logic [9:0] nwords;
  logic [7:0] pkts;
  int n_mismatch = 0, checks_done = 0, np = 0;
  always #4 clk = ~clk;

  txb_tx_path #(.DEFER_LIMIT(20)) u_dut (
    .CORE_CLK(clk), .RESET(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .TX_WORD(tw), .TX_BE(be), .TX_LAST(tl), .TX_VALID(tv), .TX_READY(tr), .TX_ABORT(ab),
    .LINE_COLLISION(co), .LINE_DEFER(defer), .LINE_BIT_TICK(1'b1), .LINE_RESULT(res),
    .LINE_DONE(dn), .TX_ERROR(terr)
  );
  txb_line_model u_line (
    .clk(clk), .rst(rst), .valid(tv), .last(tl), .be(be), .abort(ab), .slow(slow),
    .ncoll(ncoll), .ready(tr), .coll(co), .done(dn), .nbytes(nbytes), .nwords(nwords),
    .pkts(pkts), .word(tw), .first(fw)
  );

  // ----------------------------------------------------------------
  // host access and checking
  // ----------------------------------------------------------------
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) n_mismatch++;
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task put(input logic [15:0] tag, input logic [4:0] off, input logic [10:0] nb,
           input logic [10:0] pl, input logic fs, input logic ls, input logic [1:0] al);
    int a, nw;
    a = (al == 2'h1) ? 16 : (al == 2'h2) ? 32 : 4;
    nw = ((off + nb + a - 1) / a) * (a / 4);
    wb(1'b1, TXB_ADR_DATA, {6'h00, al, 3'h0, off, 2'h0, fs, ls, 1'b0, nb});
    wb(1'b1, TXB_ADR_DATA, {tag, 5'h00, pl});
    for (int i = 0; i < nw; i++) wb(1'b1, TXB_ADR_DATA, 32'h0403_0201 + i);
  endtask
  task pkt(input logic [15:0] tag, input logic [10:0] nb);
    put(tag, 5'h02, nb, nb, 1'b1, 1'b1, 2'h0);
  endtask
  task wait_pkt;
    int n;
    n = 0;
    np++;
    while (pkts !== np[7:0] && n < 3000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 3000) n_mismatch++;
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    conclude;
  end

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    wb(1'b0, TXB_ADR_CFG, 32'h0000_0000);
    chk("cfg", q, 32'h0000_0000);
    wb(1'b0, TXB_ADR_INFO, 32'h0000_0000);
    chk("info", q, 32'h0000_0200);
    wb(1'b0, 8'h10, 32'h0000_0000);
    chk("unmapped", q, 32'h0000_0000);
    pkt(16'hA001, 11'h007);
    wait_pkt;
    wb(1'b0, TXB_ADR_STAT, 32'h0000_0000);
    chk("status", q, 32'hA001_0000);
    chk("bytes", nbytes, 32'h0000_0007);
    chk("words", nwords, 32'h0000_0003);
    chk("first", fw, 32'h0403_0201);
    wb(1'b0, TXB_ADR_STAT, 32'h0000_0000);
    chk("empty", q, 32'h0000_0000);
    put(16'hB002, 5'h07, 11'h005, 11'h00A, 1'b1, 1'b0, 2'h1);
    repeat (10) @(posedge clk);
    chk("early", tv, 32'h0000_0000);
    put(16'hB002, 5'h00, 11'h004, 11'h00A, 1'b0, 1'b0, 2'h1);
    put(16'hB002, 5'h03, 11'h001, 11'h00A, 1'b0, 1'b1, 2'h2);
    wait_pkt;
    chk("bytes", nbytes, 32'h0000_000A);
    chk("words", nwords, 32'h0000_0004);
    chk("first", fw, 32'h0403_0202);
    wb(1'b0, TXB_ADR_STAT, 32'h0000_0000);
    chk("status", q, 32'hB002_0000);
    ncoll <= 5'h03;
    pkt(16'hC003, 11'h004);
    wait_pkt;
    wb(1'b0, TXB_ADR_STAT, 32'h0000_0000);
    chk("coll", q, 32'hC003_0018);
    ncoll <= 5'h11;
    pkt(16'hC004, 11'h004);
    wait_pkt;
    wb(1'b0, TXB_ADR_STAT, 32'h0000_0000);
    chk("excoll", q & 32'hFFFF_FF87, 32'hC004_8100);
    ncoll <= 5'h00;
    for (int i = 0; i < 3; i++) begin
      res <= txb_line_t'(3'h1 << i);
      pkt(16'hD005, 11'h004);
      wait_pkt;
      wb(1'b0, TXB_ADR_STAT, 32'h0000_0000);
      chk("line", q, {16'hD005, 16'h8000 | (16'h0200 << i)});
    end
    res <= '0;
    slow <= 1'b1;
    for (int c = 0; c < 2; c++) begin
      wb(1'b1, TXB_ADR_CFG, 32'(c) << 1);
      defer <= 1'b1;
      pkt(16'hE006, 11'h064);
      repeat (40) @(posedge clk);
      defer <= 1'b0;
      wait_pkt;
      wb(1'b0, TXB_ADR_STAT, 32'h0000_0000);
      chk("defer", q & 32'h0000_8005, c ? 32'h0000_8005 : 32'h0000_0001);
    end
    slow <= 1'b0;
    wb(1'b1, TXB_ADR_CFG, 32'h0000_0000);
    chk("no err", terr, 32'h0000_0000);
    put(16'hF007, 5'h02, 11'h005, 11'h006, 1'b1, 1'b1, 2'h0);
    wait_pkt;
    wb(1'b0, TXB_ADR_INFO, 32'h0000_0000);
    chk("len err", q[TXB_INFO_ERR], 32'h0000_0001);
    chk("err pin", terr, 32'h0000_0001);
    wb(1'b1, TXB_ADR_INFO, 32'h8000_0000);
    wb(1'b0, TXB_ADR_INFO, 32'h0000_0000);
    chk("cleared", q[TXB_INFO_ERR], 32'h0000_0000);
    put(16'hF008, 5'h00, 11'h004, 11'h008, 1'b1, 1'b0, 2'h0);
    put(16'hF009, 5'h00, 11'h004, 11'h008, 1'b0, 1'b1, 2'h0);
    wait_pkt;
    wb(1'b0, TXB_ADR_INFO, 32'h0000_0000);
    chk("cmdb err", q[TXB_INFO_ERR], 32'h0000_0001);
    wb(1'b1, TXB_ADR_INFO, 32'h8000_0000);
    wb(1'b0, TXB_ADR_STAT, 32'h0000_0000);
    wb(1'b0, TXB_ADR_STAT, 32'h0000_0000);
    for (int i = 0; i < 16; i++) begin
      pkt(16'h1000 + i[15:0], 11'h004);
      wait_pkt;
    end
    pkt(16'h1010, 11'h004);
    repeat (50) @(posedge clk);
    chk("stall", pkts, np[7:0]);
    wb(1'b0, TXB_ADR_INFO, 32'h0000_0000);
    chk("used", q[20:16], 32'h0000_0010);
    wb(1'b0, TXB_ADR_STAT, 32'h0000_0000);
    chk("oldest", q, 32'h1000_0000);
    wait_pkt;
    chk("resumed", pkts, np[7:0]);
    wb(1'b1, TXB_ADR_CFG, 32'h0000_0001);
    pkt(16'h1011, 11'h004);
    wait_pkt;
    wb(1'b0, TXB_ADR_INFO, 32'h0000_0000);
    chk("overrun", q & 32'h801F_0000, 32'h0000_0000);
    wb(1'b0, TXB_ADR_STAT, 32'h0000_0000);
    chk("queued", q, 32'h1001_0000);
    conclude;
  end
endmodule
